/* src/sbcg_pkg.sv */
package sbcg_pkg;
  localparam int DIV_W = 12;
  localparam logic [11:0] DIVISOR_RST = 12'h000;
  localparam logic [3:0] DIV_ASYNC_NORMAL = 4'hF; // 16 ticks per bit
  localparam logic [3:0] DIV_ASYNC_DOUBLE = 4'h7; // 8 ticks per bit
  localparam logic [3:0] DIV_SYNC_MASTER = 4'h1; // 2 ticks per bit

  typedef enum {
    SBCG_ASYNC_NORMAL,
    SBCG_ASYNC_DOUBLE,
    SBCG_SYNC_MASTER,
    SBCG_SYNC_SLAVE
  } sbcg_mode_type;

  // Software-visible configuration
  typedef struct packed {
    logic sync_mode_select;
    logic double_speed_async;
    logic transfer_clock_pin_direction;
    logic serial_power_gate;
  } sbcg_cfg_type;

  // Clocks handed to transmitter and receiver
  typedef struct packed {
    logic tx_bit_clock;
    logic rx_base_clock;
    logic [3:0] rx_states; // Last state index, states per bit less one
  } sbcg_clk_type;
endpackage : sbcg_pkg

/* src/sbcg_clock_gen.sv */
`timescale 1ns/10ps
// Operation
// - Four clocking modes feed transmitter and receiver
// - Mode select chooses asynchronous or synchronous
// - Pin direction picks master or slave
// - Transfer clock pin used only when synchronous
// - Counter reloads at zero or low write
// - Pulse at zero, rate clock over divisor+1
// - Transmit divides by sixteen, eight or two
// - Receiver steps 16, 8 or 2 states
// - Divisor is high and low, 0..4095
// - Double speed ignored in synchronous operation
// - Double speed halves receiver samples per bit
// - Slave clock synchronised, edge detected, two cycles
// - Unit runs only when power gate zero
module sbcg_clock_gen #(
  parameter int DIV_W = sbcg_pkg::DIV_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbcg_pkg::sbcg_cfg_type cfg,
  input wire logic [3:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  input wire logic baud_divisor_low_wr,
  input wire logic ext_clock_in,
  output sbcg_pkg::sbcg_clk_type clk_out,
  output logic baud_tick,
  output logic ext_clock_out,
  output logic ext_clock_oe
);

  sbcg_pkg::sbcg_mode_type mode;
  logic [11:0] baud_divisor;
  logic [11:0] cnt_q;
  logic enabled;
  logic tick;
  logic [3:0] div_q;
  logic [3:0] div_last;
  logic sync_q;
  logic prev_q;
  logic slave_rise;
  logic slave_fall;

  // Divisor width is fixed by the high and low register halves
  if (DIV_W != $bits(baud_divisor)) begin : g_width_check
    $error("divisor width must match the register halves");
  end

  // Divisor assembly
  assign baud_divisor = {baud_divisor_high, baud_divisor_low};
  assign enabled = ~cfg.serial_power_gate;

  // Mode decode; double speed only counts when asynchronous
  always_comb begin
    if (!cfg.sync_mode_select) begin
      mode = cfg.double_speed_async ? sbcg_pkg::SBCG_ASYNC_DOUBLE
                                    : sbcg_pkg::SBCG_ASYNC_NORMAL;
    end else if (cfg.transfer_clock_pin_direction) begin
      mode = sbcg_pkg::SBCG_SYNC_MASTER;
    end else begin
      mode = sbcg_pkg::SBCG_SYNC_SLAVE;
    end
  end

  // Divide ratio per mode
  always_comb begin
    case (mode)
      sbcg_pkg::SBCG_ASYNC_NORMAL: div_last = sbcg_pkg::DIV_ASYNC_NORMAL;
      sbcg_pkg::SBCG_ASYNC_DOUBLE: div_last = sbcg_pkg::DIV_ASYNC_DOUBLE;
      sbcg_pkg::SBCG_SYNC_MASTER: div_last = sbcg_pkg::DIV_SYNC_MASTER;
      default: div_last = sbcg_pkg::DIV_SYNC_MASTER;
    endcase
  end

  assign tick = enabled && (cnt_q == 12'h000);

  // Baud down-counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= sbcg_pkg::DIVISOR_RST;
    end else if (!enabled || baud_divisor_low_wr || cnt_q == 12'h000) begin
      cnt_q <= baud_divisor;
    end else begin
      cnt_q <= cnt_q - 12'h001;
    end
  end

  // Generator output pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= tick;
    end
  end

  // Bit divider / receiver state counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
    end else if (!enabled || mode == sbcg_pkg::SBCG_SYNC_SLAVE) begin
      div_q <= 4'h0;
    end else if (tick) begin
      div_q <= (div_q >= div_last) ? 4'h0 : div_q + 4'h1;
    end
  end

  // Pin sampling register then edge detector: two cycles to the outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync_q <= ext_clock_in;
      prev_q <= sync_q;
    end
  end

  assign slave_rise = sync_q & ~prev_q;
  assign slave_fall = ~sync_q & prev_q;

  // Transmit bit clock and receiver base clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out <= '0;
    end else if (!enabled) begin
      clk_out <= '0;
    end else if (mode == sbcg_pkg::SBCG_SYNC_SLAVE) begin
      clk_out.tx_bit_clock <= slave_rise;
      clk_out.rx_base_clock <= slave_rise | slave_fall;
      clk_out.rx_states <= sbcg_pkg::DIV_SYNC_MASTER;
    end else begin
      clk_out.tx_bit_clock <= tick && (div_q == div_last);
      clk_out.rx_base_clock <= tick;
      clk_out.rx_states <= div_last;
    end
  end

  // Pin drive: only in synchronous master mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clock_out <= 1'b0;
      ext_clock_oe <= 1'b0;
    end else begin
      ext_clock_oe <= enabled && mode == sbcg_pkg::SBCG_SYNC_MASTER;
      if (enabled && mode == sbcg_pkg::SBCG_SYNC_MASTER) begin
        ext_clock_out <= div_q[0];
      end else begin
        ext_clock_out <= 1'b0;
      end
    end
  end

  // Assertions
  property p_tick_reload;
    @(posedge clk) disable iff (!rst_n)
      (enabled && cnt_q == 12'h000 && !baud_divisor_low_wr)
        |=> cnt_q == $past(baud_divisor);
  endproperty
  a_tick_reload: assert property (p_tick_reload)
    else $error("counter not reloaded at zero");

  property p_wr_reload;
    @(posedge clk) disable iff (!rst_n)
      baud_divisor_low_wr |=> cnt_q == $past(baud_divisor);
  endproperty
  a_wr_reload: assert property (p_wr_reload)
    else $error("counter not reloaded on low write");

  property p_pulse;
    @(posedge clk) disable iff (!rst_n) tick |=> baud_tick;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("baud pulse missing");

  property p_power;
    @(posedge clk) disable iff (!rst_n)
      cfg.serial_power_gate |=> !clk_out.rx_base_clock && !ext_clock_oe;
  endproperty
  a_power: assert property (p_power)
    else $error("clocks active while gated");

  property p_async_pin;
    @(posedge clk) disable iff (!rst_n)
      !cfg.sync_mode_select |=> !ext_clock_oe;
  endproperty
  a_async_pin: assert property (p_async_pin)
    else $error("pin driven in async mode");

  property p_slave_edge;
    @(posedge clk) disable iff (!rst_n)
      (mode == sbcg_pkg::SBCG_SYNC_SLAVE && enabled && slave_rise)
        |=> clk_out.tx_bit_clock;
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave edge not passed on");

  property p_rx_states;
    @(posedge clk) disable iff (!rst_n)
      (enabled && mode == sbcg_pkg::SBCG_ASYNC_DOUBLE)
        |=> clk_out.rx_states == sbcg_pkg::DIV_ASYNC_DOUBLE;
  endproperty
  a_rx_states: assert property (p_rx_states)
    else $error("double speed rx states wrong");

  property p_tx_needs_tick;
    @(posedge clk) disable iff (!rst_n)
      (mode != sbcg_pkg::SBCG_SYNC_SLAVE && $past(mode) == mode)
        && clk_out.tx_bit_clock |-> $past(tick);
  endproperty
  a_tx_needs_tick: assert property (p_tx_needs_tick)
    else $error("tx clock without baud tick");

  // Master pin carries the divided generator clock
  property p_pin_follow;
    @(posedge clk) disable iff (!rst_n)
      (enabled && mode == sbcg_pkg::SBCG_SYNC_MASTER)
        |=> ext_clock_out == $past(div_q[0]);
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("master pin clock wrong");

  // Rising pin edge reaches the transmit clock two cycles later
  property p_slave_delay;
    @(posedge clk) disable iff (!rst_n)
      (mode == sbcg_pkg::SBCG_SYNC_SLAVE && enabled && $rose(ext_clock_in))
        ##1 (mode == sbcg_pkg::SBCG_SYNC_SLAVE && enabled)
        |=> clk_out.tx_bit_clock;
  endproperty
  a_slave_delay: assert property (p_slave_delay)
    else $error("slave edge delay wrong");

  c_master: cover property (@(posedge clk) ext_clock_oe && ext_clock_out);
  c_slave: cover property (@(posedge clk)
    mode == sbcg_pkg::SBCG_SYNC_SLAVE && clk_out.tx_bit_clock);
  c_double: cover property (@(posedge clk)
    mode == sbcg_pkg::SBCG_ASYNC_DOUBLE && clk_out.tx_bit_clock);

endmodule : sbcg_clock_gen

/* tb/sbcg_peer.sv */
`timescale 1ns/10ps
// Remote master toggling the transfer clock, still when idle
module sbcg_peer #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic run,
  output logic ext_clock
);
  int cnt = 0;
  // Period of 8 system cycles stays below a quarter of clk
  always @(negedge clk) begin
    if (!run) begin
      cnt <= 0;
      ext_clock <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clock <= ~ext_clock;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : sbcg_peer

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sbcg_pkg::sbcg_cfg_type cfg = 4'h0;
  logic [3:0] dh = 4'h0;
  logic [7:0] dl = 8'h00;
  logic dw = 1'b0;
  logic pin, tick, xo, xoe;
  sbcg_pkg::sbcg_clk_type co;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [3:0] md [4] = '{4'h0, 4'h4, 4'hE, 4'h8};
  int ex_tx [4] = '{32, 16, 4, 8};
  int ex_rx [4] = '{2, 2, 2, 4};
  logic [3:0] ex_st [4] = '{4'hF, 4'h7, 4'h1, 4'h1};
  logic ex_oe [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int ex_xo [4] = '{0, 0, 32, 0};
  always #10 clk = ~clk;
  sbcg_clock_gen i_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg),
    .baud_divisor_high(dh), .baud_divisor_low(dl),
    .baud_divisor_low_wr(dw), .ext_clock_in(pin), .clk_out(co),
    .baud_tick(tick), .ext_clock_out(xo), .ext_clock_oe(xoe));
  sbcg_peer i_peer (.clk(clk), .ext_clock(pin),
    .run(cfg.sync_mode_select & ~cfg.transfer_clock_pin_direction));
  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Divisor write with low-byte strobe
  task set_div(input logic [11:0] v);
    @(negedge clk);
    dh = v[11:8];
    dl = v[7:0];
    dw = 1'b1;
    @(negedge clk);
    dw = 1'b0;
  endtask : set_div
  function logic sig(input int s);
    case (s)
      0: sig = tick;
      1: sig = co.tx_bit_clock;
      default: sig = co.rx_base_clock;
    endcase
  endfunction : sig
  // Cycles between two pulses, measured twice to settle
  task per(input int s, output int p);
    repeat (2) begin
      p = 0;
      while (!sig(s) && p < 9000) begin
        @(negedge clk);
        p++;
      end
      @(negedge clk);
      p = 1;
      while (!sig(s) && p < 9000) begin
        @(negedge clk);
        p++;
      end
    end
  endtask : per
  task results;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    set_div(12'h001);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      cfg = md[i];
      per(1, n);
      chk(n, ex_tx[i]);
      per(2, n);
      chk(n, ex_rx[i]);
      chk(co.rx_states, ex_st[i]);
      chk(xoe, ex_oe[i]);
      n = 0;
      repeat (64) begin
        @(negedge clk);
        n += xo;
      end
      chk(n, ex_xo[i]);
    end
    cfg = 4'h0;
    set_div(12'hFFF);
    per(0, n);
    chk(n, 4096);
    set_div(12'h001);
    n = 0;
    while (!tick && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(n < 4, 1'b1);
    cfg = 4'h1;
    n = 0;
    repeat (200) begin
      @(negedge clk);
      n += tick | co.tx_bit_clock;
    end
    chk(n, 0);
    results();
  end
endmodule : tb_top
